// [hdl/pas_pkg.sv]
// Package for the pipelined sample output block: widths, codes, timing.
// Assumes a single 25 MHz system clock domain.
package pas_pkg;

    // ------------------------------------------------------------
    // Data format
    // ------------------------------------------------------------
    localparam int unsigned WORD_W = 12;
    localparam logic [11:0] CODE_MAX = 12'h7ff;
    localparam logic [11:0] CODE_MIN = 12'h800;
    localparam logic [11:0] WORD_RST = 12'h000;
    localparam int unsigned PIPE_DEPTH = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned CONV_TIME_NS = 150;
    // Longest time, rounded down to whole cycles.
    localparam int unsigned CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned IDLE_TIME_US = 1000;
    localparam int unsigned IDLE_CYC_DEF = IDLE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned IDLE_W = 16;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PAS_REF_HIGH = 2'b00,
        PAS_REF_LOW = 2'b01,
        PAS_REF_EXT = 2'b10
    } pas_ref_e;

    typedef enum logic [0:0] {
        PAS_GAIN_2X = 1'b0,
        PAS_GAIN_1X = 1'b1
    } pas_gain_e;

    // One digitised sample travelling through the pipeline.
    typedef struct packed {
        logic valid;
        logic [11:0] code;
    } pas_stage_s;

    // Strap inputs for reference mode: ground, tied to ref, tied to supply.
    typedef struct packed {
        logic tied_ref;
        logic tied_supply;
    } pas_strap_s;

endpackage : pas_pkg

// [hdl/pas_refresh_timer.sv]
// Idle refresh timer: pulses when no conversion start was seen for long.
// Assumes conv_start_i is a one-cycle pulse in the ref_clk_i domain.
`timescale 1ns/1ps
module pas_refresh_timer #(
    parameter logic [15:0] IDLE_CYC = 16'(pas_pkg::IDLE_CYC_DEF)
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Activity
    input wire logic conv_start_i,
    // Refresh
    output logic refresh_o
);
    logic [15:0] idle_cnt_r;
    logic [15:0] idle_cnt_nxt;
    wire at_limit = (idle_cnt_r == IDLE_CYC - 16'h0001);

    assign idle_cnt_nxt = (conv_start_i || at_limit) ? 16'h0000
                                                      : idle_cnt_r + 16'h0001;
    assign refresh_o = at_limit && !conv_start_i;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            idle_cnt_r <= 16'h0000;
        end else begin
            idle_cnt_r <= idle_cnt_nxt;
        end
    end

    idle_refresh_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        refresh_o |-> !$past(conv_start_i))
        else $error("refresh issued right after a conversion start");
endmodule : pas_refresh_timer

// [hdl/pas_sample_out.sv]
// Digital core of a 12-bit pipelined converter: start, latency, output word.
// Assumes the conversion clock is a level sampled on ref_clk_i and the
// digitised code arrives from the analog front end at each start.
`timescale 1ns/1ps

module pas_sample_out #(
    parameter logic [15:0] IDLE_CYC = 16'(pas_pkg::IDLE_CYC_DEF)
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Conversion clock from capture logic
    input wire logic conv_clk_i,
    // Digitised differential input from the front end
    input wire logic [11:0] front_code_i,
    // Straps
    input wire logic gain_sel_i,
    input wire pas_pkg::pas_strap_s ref_strap_i,
    // Results
    output logic [11:0] sample_word_out,
    output logic overflow_flag,
    output logic result_update_o,
    // Front-end controls
    output logic sample_hold_o,
    output pas_pkg::pas_gain_e pga_gain_o,
    output pas_pkg::pas_ref_e ref_mode_o,
    output logic ref_driver_en_o,
    output logic refresh_o
);
    // ------------------------------------------------------------
    // Conversion start detection
    // ------------------------------------------------------------
    logic conv_clk_r;
    wire conv_start = conv_clk_i && !conv_clk_r;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            conv_clk_r <= 1'b0;
        end else begin
            conv_clk_r <= conv_clk_i;
        end
    end

    // Both inputs are captured by one strobe, so they share the instant.
    assign sample_hold_o = conv_start;

    // ------------------------------------------------------------
    // Pipeline, advanced once per conversion start
    // ------------------------------------------------------------
    // The output register below is the last of the three stages.
    pas_pkg::pas_stage_s stage_r [pas_pkg::PIPE_DEPTH - 1];

    genvar gi;
    generate
        for (gi = 0; gi < pas_pkg::PIPE_DEPTH - 1; gi++) begin : g_stage
            pas_pkg::pas_stage_s stage_nxt;
            if (gi == 0) begin : g_first
                assign stage_nxt = '{valid: 1'b1, code: front_code_i};
            end else begin : g_next
                assign stage_nxt = stage_r[gi-1];
            end
            always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    stage_r[gi] <= '{valid: 1'b0, code: pas_pkg::WORD_RST};
                end else if (conv_start) begin
                    stage_r[gi] <= stage_nxt;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Output register
    // ------------------------------------------------------------
    // The second start after sampling pushes the result onto the pins;
    // the result from stage two lands here on the clock edge that ends that start,
    // with no wait for the conversion time, since CONV_CYC is not used here.
    wire ready_now = conv_start && stage_r[1].valid;
    logic [11:0] word_r;
    logic [11:0] word_nxt;
    logic ovf_r;
    logic ovf_nxt;
    logic upd_r;

    assign word_nxt = ready_now ? stage_r[1].code : word_r;
    assign ovf_nxt = ready_now ? ((stage_r[1].code == pas_pkg::CODE_MAX) ||
                     (stage_r[1].code == pas_pkg::CODE_MIN)) : ovf_r;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            word_r <= pas_pkg::WORD_RST;
            ovf_r <= 1'b0;
            upd_r <= 1'b0;
        end else begin
            word_r <= word_nxt;
            ovf_r <= ovf_nxt;
            upd_r <= ready_now;
        end
    end

    assign sample_word_out = word_r;
    assign overflow_flag = ovf_r;
    assign result_update_o = upd_r;

    // ------------------------------------------------------------
    // Straps
    // ------------------------------------------------------------
    assign pga_gain_o = gain_sel_i ? pas_pkg::PAS_GAIN_1X
                                   : pas_pkg::PAS_GAIN_2X;
    assign ref_mode_o = ref_strap_i.tied_supply ? pas_pkg::PAS_REF_EXT :
                        ref_strap_i.tied_ref ? pas_pkg::PAS_REF_LOW :
                        pas_pkg::PAS_REF_HIGH;
    assign ref_driver_en_o = !ref_strap_i.tied_supply;

    // ------------------------------------------------------------
    // Idle refresh
    // ------------------------------------------------------------
    pas_refresh_timer #(
        .IDLE_CYC(IDLE_CYC)
    ) u_refresh (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .conv_start_i(conv_start),
        .refresh_o(refresh_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence start_s;
        conv_start;
    endsequence

    // Helpers: codes of the last two starts and a count of starts since
    // reset that holds at two, kept apart from the pipeline so that its latency is checked.
    logic [11:0] code_d1_r;
    logic [11:0] code_d2_r;
    logic [1:0] fill_r;
    wire fill_done = (fill_r == 2'h2);

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            code_d1_r <= pas_pkg::WORD_RST;
            code_d2_r <= pas_pkg::WORD_RST;
            fill_r <= 2'h0;
        end else if (conv_start) begin
            code_d1_r <= front_code_i;
            code_d2_r <= code_d1_r;
            fill_r <= fill_done ? fill_r : fill_r + 2'h1;
        end
    end

    start_strobe_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        $rose(conv_clk_i) |-> sample_hold_o)
        else $error("no sample strobe on conversion clock rise");

    latency_out_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i) (conv_start && fill_done) |=>
        result_update_o && sample_word_out == $past(code_d2_r))
        else $error("output word not from the third start");

    pipe_fill_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i) (conv_start && !fill_done) |=>
        !result_update_o)
        else $error("update before the pipeline filled");

    pipe_order_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i) start_s ##1 (!conv_start [*1]) |->
        stage_r[0].code == code_d1_r && stage_r[1].code == code_d2_r)
        else $error("pipeline stages do not hold the sampled codes");

    overflow_code_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        overflow_flag == ((sample_word_out == pas_pkg::CODE_MAX) ||
        (sample_word_out == pas_pkg::CODE_MIN)))
        else $error("overflow flag disagrees with word");

    word_hold_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        !result_update_o |-> $stable(sample_word_out))
        else $error("word moved without an update");

    gain_map_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        pga_gain_o == (gain_sel_i ? pas_pkg::PAS_GAIN_1X
        : pas_pkg::PAS_GAIN_2X))
        else $error("gain select mapped wrongly");

    ref_ext_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        ref_strap_i.tied_supply |-> !ref_driver_en_o &&
        ref_mode_o == pas_pkg::PAS_REF_EXT)
        else $error("external reference did not free the driver");

    update_pulse_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        result_update_o |=> !result_update_o)
        else $error("update strobe longer than one cycle");
endmodule : pas_sample_out

// [verif/pas_capture_model.sv]
// Capture-side model: makes the conversion clock and latches results.
// Assumes the bench sets run_i and half_i shortly after a ref_clk_i edge.
`timescale 1ns/1ps
module pas_capture_model (
    // Clock
    input wire logic ref_clk_i,
    // Control
    input wire logic run_i,
    input wire logic [3:0] half_i,
    // Results
    input wire logic upd_i,
    input wire logic [11:0] word_i,
    // Outputs
    output logic conv_clk_o,
    output logic [11:0] cap_word_o,
    output logic [11:0] cap_bin_o
);
    logic [3:0] cnt_r;
    initial begin
        conv_clk_o = 1'b0;
        cnt_r = 4'h0;
        cap_word_o = 12'h000;
    end
    // The clock rests low outside a run; half_i of one keeps starts apart.
    always @(posedge ref_clk_i) begin
        if (upd_i) cap_word_o <= word_i;
        if (cnt_r + 4'h1 >= half_i) begin
            cnt_r <= #1 4'h0;
            conv_clk_o <= #1 run_i & ~conv_clk_o;
        end else begin
            cnt_r <= #1 cnt_r + 4'h1;
        end
    end
    assign cap_bin_o = {~cap_word_o[11], cap_word_o[10:0]};
endmodule : pas_capture_model

// [verif/testbench.sv]
// Self-checking bench for the sample output block.
// Assumes a 25 MHz clock and a shortened idle refresh count of 16.
`timescale 1ns/1ps
module testbench;
    logic ref_clk_i, sys_rst_i, conv_clk_i, gain_sel_i, run, upd, flag;
    logic hold, drv_en, refresh, cap_due, exp_f;
    logic [3:0] half;
    logic [11:0] front_code_i, word, prev_w, exp_w, cap_w, cap_b;
    pas_pkg::pas_strap_s ref_strap_i;
    pas_pkg::pas_gain_e gain;
    pas_pkg::pas_ref_e mode;
    logic [11:0] codes [8] = '{12'h7ff, 12'h800, 12'h000, 12'h7fe,
                               12'h801, 12'hfff, 12'h001, 12'ha5c};
    logic [11:0] sent [$];
    int err_count = 0, total_checks = 0, starts = 0, ups = 0, idx = 0;
    int refr = 0;
    pas_sample_out #(.IDLE_CYC(16'h0010)) dut (.ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i), .conv_clk_i(conv_clk_i),
        .front_code_i(front_code_i), .gain_sel_i(gain_sel_i),
        .ref_strap_i(ref_strap_i), .sample_word_out(word),
        .overflow_flag(flag), .result_update_o(upd),
        .sample_hold_o(hold), .pga_gain_o(gain), .ref_mode_o(mode),
        .ref_driver_en_o(drv_en), .refresh_o(refresh));
    pas_capture_model far (.ref_clk_i(ref_clk_i), .run_i(run),
        .half_i(half), .upd_i(upd), .word_i(word), .conv_clk_o(conv_clk_i),
        .cap_word_o(cap_w), .cap_bin_o(cap_b));
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    // ------------------------------------------------------------
    // Front-end feed and result monitor
    // ------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            prev_w = 12'h000;
            cap_due = 1'b0;
        end else begin
            if (cap_due) begin
                chk(cap_w, exp_w);
                chk(cap_b, exp_w ^ 12'h800);
            end
            cap_due = upd;
            if (upd) begin
                exp_w = sent[ups];
                exp_f = (exp_w == 12'h7ff) || (exp_w == 12'h800);
                chk(word, exp_w);
                chk(12'(flag), 12'(exp_f));
                chk(12'(starts - ups), 12'h003);
                ups++;
            end else begin
                chk(word, prev_w);
            end
            prev_w = word;
            if (refresh) refr++;
            if (hold) begin
                sent.push_back(front_code_i);
                starts++;
                idx++;
                front_code_i <= #1 codes[idx % 8];
            end
        end
    end
    task automatic t_stream(input logic [3:0] h, input int n);
        int k;
        half <= #1 h;
        run <= #1 1'b1;
        k = starts + 2;
        repeat (100) if (starts < k) @(posedge ref_clk_i);
        refr = 0;
        k = ups + n;
        repeat (400) if (ups < k) @(posedge ref_clk_i);
        chk(12'(ups >= k), 12'h001);
        chk(12'(refr), 12'h000);
        run <= #1 1'b0;
        repeat (20) @(posedge ref_clk_i);
        $display("test stream half=%0d done", h);
    endtask : t_stream
    task automatic t_refresh();
        int k;
        k = 0;
        repeat (40) if (!refresh) @(posedge ref_clk_i);
        @(posedge ref_clk_i);
        while (!refresh && k < 40) begin
            k++;
            @(posedge ref_clk_i);
        end
        chk(12'(k + 1), 12'h010);
        $display("test refresh done");
    endtask : t_refresh
    task automatic t_straps();
        for (int g = 0; g < 2; g++) begin
            for (int s = 0; s < 4; s++) begin
                gain_sel_i <= #1 g[0];
                ref_strap_i <= #1 s[1:0];
                @(posedge ref_clk_i);
                #2;
                chk(12'(gain), 12'(g));
                chk(12'(mode), s[0] ? 12'h2 : s[1] ? 12'h1 : 12'h0);
                chk(12'(drv_en), 12'(!s[0]));
            end
        end
        $display("test straps done");
    endtask : t_straps
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #400000;
        err_count++;
        close_out();
    end
    initial begin
        sys_rst_i = 1'b1;
        run = 1'b0;
        half = 4'h1;
        gain_sel_i = 1'b1;
        ref_strap_i = '0;
        front_code_i = codes[0];
        repeat (8) @(posedge ref_clk_i);
        sys_rst_i <= #1 1'b0;
        t_stream(4'h1, 12);
        t_refresh();
        t_stream(4'h4, 6);
        t_straps();
        t_stream(4'h2, 5);
        close_out();
    end
endmodule : testbench
